// file: hw/chan_term_pkg.sv
// Constants, carriers and state codes for the channel/EOI/terminator interpreter.
// Assumes one 200 MHz clock; byte values are ASCII codes seen on the bus.
package chan_term_pkg;

  // ==========================================================
  // Command characters
  localparam logic [7:0] CH_EXEC  = 8'h58;
  localparam logic [7:0] CMD_CHAN = 8'h43;
  localparam logic [7:0] CMD_EOI  = 8'h4b;
  localparam logic [7:0] CMD_TERM = 8'h59;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_DIG0  = 8'h30;
  localparam logic [7:0] CH_DIG9  = 8'h39;
  localparam logic [7:0] CH_LETA  = 8'h41;
  localparam logic [7:0] CH_LETZ  = 8'h5a;

  // ==========================================================
  // Option values and defaults
  localparam logic [7:0] OPT_CH1   = 8'h01;
  localparam logic [7:0] OPT_CH2   = 8'h02;
  localparam logic [7:0] OPT_COMP  = 8'h0c;
  localparam logic [7:0] OPT_KMAX  = 8'h03;
  localparam int         KB_EOI    = 0;
  localparam int         KB_HOLD   = 1;
  localparam logic [7:0] TERM_CR   = 8'h0d;
  localparam logic [7:0] TERM_LF   = 8'h0a;
  localparam logic [1:0] TLEN_NONE = 2'h0;
  localparam logic [1:0] TLEN_ONE  = 2'h1;
  localparam logic [1:0] TLEN_TWO  = 2'h2;
  localparam int         BUF_DEPTH = 16;
  localparam logic [4:0] BUF_FULL  = 5'h10;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       eoi_en;
    logic       hold_en;
    logic [1:0] term_len;
    logic [7:0] term0;
    logic [7:0] term1;
  } cfg_t;

  localparam cfg_t CFG_RST = '{eoi_en: 1'b1, hold_en: 1'b1, term_len: TLEN_TWO,
                               term0: TERM_CR, term1: TERM_LF};

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } talk_t;

  // ==========================================================
  // States
  typedef enum logic [1:0] {P_IDLE = 2'b01, P_RUN = 2'b10} pstate_t;
  typedef enum logic [2:0] {T_DATA = 3'b001, T_TERM0 = 3'b010, T_TERM1 = 3'b100} tstate_t;
  typedef enum logic [4:0] {K_NONE = 5'b00001, K_CHAN = 5'b00010, K_EOI = 5'b00100,
                            K_TERM = 5'b01000, K_OTHER = 5'b10000} kind_t;

  function automatic logic is_digit(input logic [7:0] b);
    return (b >= CH_DIG0) && (b <= CH_DIG9);
  endfunction

  function automatic logic is_letter(input logic [7:0] b);
    return (b >= CH_LETA) && (b <= CH_LETZ);
  endfunction

endpackage

// file: hw/chan_term_ctl.sv
// Channel select, EOI/hold-off and terminator interpreter with talker framing.
// Assumes bus handshake logic on the same clock delivers listener bytes and
// drains talker bytes; bus clear is a one-cycle pulse from that logic.
//
// Overview of operation
// - Active channel sources the displayed reading
// - Panel settings per channel; bus settings shared
// - Composite mode refuses all programming but channel commands
// - Reset and bus clear select channel one
// - Channel two without module: message, optional SRQ
// - EOI command options 0..3 decode two disables
// - Reset and bus clear restore EOI, hold-off on
// - EOI only with final byte of transmission
// - EOI rides last terminator or last data
// - Hold NRFD from execute until commands done
// - Terminator takes one, two or no values
// - Reset and bus clear restore CR then LF
// - Terminator once at end; format seven none
// - Non-channel command in composite sets error flag
`timescale 1ns/1ps
`default_nettype none

module chan_term_ctl
  (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Listener bytes and bus clear
    input  wire logic [7:0]          cmd_data,
    input  wire logic                cmd_valid,
    output logic                     cmd_ready,
    output logic                     nrfd_hold,
    input  wire logic                bus_clear,
    // Module presence and status
    input  wire logic                ch2_fitted_pin,
    input  wire logic                srq_on_missing,
    input  wire logic                err_clr,
    output logic                     error,
    output logic                     srq_req,
    output logic                     missing_msg,
    // Channel state and readings
    input  wire logic [15:0]         rd_ch1,
    input  wire logic [15:0]         rd_ch2,
    input  wire logic                panel_wr,
    input  wire logic [7:0]          panel_val,
    output logic [7:0]               panel_active,
    output logic [15:0]              disp_reading,
    output logic                     chan2_sel,
    output logic                     composite,
    output chan_term_pkg::cfg_t      cfg,
    // Talker stream
    input  wire logic [7:0]          tx_data,
    input  wire logic                tx_valid,
    input  wire logic                tx_last,
    input  wire logic                unterminated_data_format,
    output logic                     tx_ready,
    output chan_term_pkg::talk_t     talk,
    output logic                     talk_valid,
    input  wire logic                talk_ready
  );
  import chan_term_pkg::*;

  logic [7:0]  buf_q [BUF_DEPTH];
  logic [4:0]  cnt_q, rd_q;
  pstate_t     pst_q, pst_d;
  kind_t       kind_q;
  logic [7:0]  num_q, first_q;
  logic        hasdig_q, ycnt_q;
  logic [2:0]  sync_q;
  logic        fitted_q, chan2_q, comp_q, err_q, srq_q, miss_q, hold_q, crdy_q;
  cfg_t        cfg_q;
  logic [7:0]  panel_q [2];
  logic [7:0]  pact_q;
  logic [15:0] disp_q;
  tstate_t     tst_q, tst_d;
  talk_t       out_q;
  logic        oval_q, oval_d, trdy_q;

  // ==========================================================
  // Module presence pin: three stages, change taken when last two agree
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], ch2_fitted_pin};

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      fitted_q <= 1'b0;
    else if (sync_q[1] == sync_q[2])
      fitted_q <= sync_q[2];

  // ==========================================================
  // Command collection and execute
  logic       take, is_exec, step, at_end, boundary, fire;
  logic [7:0] b;
  assign take     = cmd_valid && crdy_q;
  assign is_exec  = cmd_data == CH_EXEC;
  assign step     = pst_q == P_RUN;
  assign at_end   = rd_q == cnt_q;
  assign b        = buf_q[rd_q[3:0]];
  assign boundary = step && (at_end || is_letter(b));
  assign fire     = boundary && (kind_q != K_NONE);

  always_comb
  begin
    pst_d = pst_q;
    if (bus_clear)
      pst_d = P_IDLE;
    else if (pst_q == P_IDLE && take && is_exec)
      pst_d = P_RUN;
    else if (step && at_end)
      pst_d = P_IDLE;
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      pst_q <= P_IDLE;
    else
      pst_q <= pst_d;

  always_ff @(posedge clk)
    if (take && !is_exec && cnt_q != BUF_FULL)
      buf_q[cnt_q[3:0]] <= cmd_data;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      cnt_q <= 5'h00;
    else if (bus_clear || (step && at_end))
      cnt_q <= 5'h00;
    else if (take && !is_exec && cnt_q != BUF_FULL)
      cnt_q <= cnt_q + 5'h01;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rd_q <= 5'h00;
    else if (!step)
      rd_q <= 5'h00;
    else if (!at_end)
      rd_q <= rd_q + 5'h01;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      hold_q <= 1'b0;
    else if (pst_d != P_RUN)
      hold_q <= 1'b0;
    else if (pst_q == P_IDLE)
      hold_q <= cfg_q.hold_en;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      crdy_q <= 1'b0;
    else
      crdy_q <= pst_d == P_IDLE;

  // ==========================================================
  // Token parsing
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      kind_q   <= K_NONE;
      num_q    <= 8'h00;
      first_q  <= 8'h00;
      hasdig_q <= 1'b0;
      ycnt_q   <= 1'b0;
    end
    else if (!step || at_end)
      kind_q <= K_NONE;
    else if (is_letter(b))
    begin
      kind_q   <= (b == CMD_CHAN) ? K_CHAN : (b == CMD_EOI) ? K_EOI :
                  (b == CMD_TERM) ? K_TERM : K_OTHER;
      num_q    <= 8'h00;
      hasdig_q <= 1'b0;
      ycnt_q   <= 1'b0;
    end
    else if (is_digit(b))
    begin
      num_q    <= num_q * 8'h0a + (b - CH_DIG0);
      hasdig_q <= 1'b1;
    end
    else if (b == CH_COMMA && kind_q == K_TERM)
    begin
      first_q  <= num_q;
      ycnt_q   <= 1'b1;
      num_q    <= 8'h00;
      hasdig_q <= 1'b0;
    end

  // ==========================================================
  // Command effects
  logic set_ch1, set_ch2, set_comp, set_k, set_y, bad, missing;
  always_comb
  begin
    set_ch1  = 1'b0;
    set_ch2  = 1'b0;
    set_comp = 1'b0;
    set_k    = 1'b0;
    set_y    = 1'b0;
    bad      = 1'b0;
    missing  = 1'b0;
    if (fire)
      case (kind_q)
        K_CHAN:
          if (hasdig_q && num_q == OPT_CH1)
            set_ch1 = 1'b1;
          else if (hasdig_q && num_q == OPT_CH2)
          begin
            set_ch2 = fitted_q;
            missing = !fitted_q;
          end
          else if (hasdig_q && num_q == OPT_COMP)
            set_comp = 1'b1;
          else
            bad = 1'b1;
        K_EOI:
          if (comp_q)
            bad = 1'b1;
          else if (!hasdig_q || num_q > OPT_KMAX)
            bad = 1'b1;
          else
            set_k = 1'b1;
        K_TERM:
          if (comp_q)
            bad = 1'b1;
          else
            set_y = 1'b1;
        K_OTHER:
          bad = comp_q;
        default:
          bad = 1'b0;
      endcase
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      chan2_q <= 1'b0;
      comp_q  <= 1'b0;
    end
    else if (bus_clear)
    begin
      chan2_q <= 1'b0;
      comp_q  <= 1'b0;
    end
    else if (set_ch1 || set_ch2)
    begin
      chan2_q <= set_ch2;
      comp_q  <= 1'b0;
    end
    else if (set_comp)
      comp_q <= 1'b1;

  // Bus-only settings are shared by both channels
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      cfg_q <= CFG_RST;
    else if (bus_clear)
      cfg_q <= CFG_RST;
    else if (set_k)
    begin
      cfg_q.eoi_en  <= !num_q[KB_EOI];
      cfg_q.hold_en <= !num_q[KB_HOLD];
    end
    else if (set_y)
    begin
      if (ycnt_q)
      begin
        cfg_q.term_len <= TLEN_TWO;
        cfg_q.term0    <= first_q;
        cfg_q.term1    <= num_q;
      end
      else if (hasdig_q)
      begin
        cfg_q.term_len <= TLEN_ONE;
        cfg_q.term0    <= num_q;
      end
      else
        cfg_q.term_len <= TLEN_NONE;
    end

  // Front-panel settings kept per channel
  always_ff @(posedge clk)
    if (panel_wr && !comp_q)
      panel_q[chan2_q] <= panel_val;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      pact_q <= 8'h00;
      disp_q <= 16'h0000;
    end
    else
    begin
      pact_q <= panel_q[chan2_q];
      disp_q <= chan2_q ? rd_ch2 : rd_ch1;
    end

  // ==========================================================
  // Status
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      err_q  <= 1'b0;
      srq_q  <= 1'b0;
      miss_q <= 1'b0;
    end
    else
    begin
      if (bad || missing || (take && !is_exec && cnt_q == BUF_FULL))
        err_q <= 1'b1;
      else if (err_clr)
        err_q <= 1'b0;
      srq_q  <= missing && srq_on_missing;
      miss_q <= missing;
    end

  // ==========================================================
  // Talker framing
  logic acc, tload;
  assign acc   = tx_valid && trdy_q;
  assign tload = !oval_q && (tst_q != T_DATA);

  always_comb
  begin
    tst_d  = tst_q;
    oval_d = oval_q && !talk_ready;
    if (acc && tx_last && !unterminated_data_format && cfg_q.term_len != TLEN_NONE)
      tst_d = T_TERM0;
    else if (tload && tst_q == T_TERM0 && cfg_q.term_len == TLEN_TWO)
      tst_d = T_TERM1;
    else if (tload)
      tst_d = T_DATA;
    if (acc || tload)
      oval_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tst_q  <= T_DATA;
      oval_q <= 1'b0;
      trdy_q <= 1'b0;
      out_q  <= '0;
    end
    else
    begin
      tst_q  <= tst_d;
      oval_q <= oval_d;
      trdy_q <= (tst_d == T_DATA) && !oval_d;
      if (acc)
      begin
        out_q.data <= tx_data;
        out_q.eoi  <= cfg_q.eoi_en && tx_last && (tst_d == T_DATA);
      end
      else if (tload)
      begin
        out_q.data <= (tst_q == T_TERM0) ? cfg_q.term0 : cfg_q.term1;
        out_q.eoi  <= cfg_q.eoi_en && (tst_d == T_DATA);
      end
    end

  assign cmd_ready    = crdy_q;
  assign nrfd_hold    = hold_q;
  assign error        = err_q;
  assign srq_req      = srq_q;
  assign missing_msg  = miss_q;
  assign panel_active = pact_q;
  assign disp_reading = disp_q;
  assign chan2_sel    = chan2_q;
  assign composite    = comp_q;
  assign cfg          = cfg_q;
  assign tx_ready     = trdy_q;
  assign talk         = out_q;
  assign talk_valid   = oval_q;

  // ==========================================================
  // Checks
  property p_clr_chan;
    @(posedge clk) disable iff (!rstn) bus_clear |=> !chan2_q && !comp_q;
  endproperty
  a_clr_chan: assert property (p_clr_chan) else $error("channel not reset");

  property p_clr_k;
    @(posedge clk) disable iff (!rstn) bus_clear |=> cfg_q.eoi_en && cfg_q.hold_en;
  endproperty
  a_clr_k: assert property (p_clr_k) else $error("EOI mode not reset");

  property p_clr_term;
    @(posedge clk) disable iff (!rstn)
      bus_clear |=> cfg_q.term_len == TLEN_TWO && cfg_q.term0 == TERM_CR && cfg_q.term1 == TERM_LF;
  endproperty
  a_clr_term: assert property (p_clr_term) else $error("terminator not reset");

  property p_comp_lock;
    @(posedge clk) disable iff (!rstn)
      comp_q && fire && !bus_clear && (kind_q == K_EOI || kind_q == K_TERM) |=> $stable(cfg_q) && err_q;
  endproperty
  a_comp_lock: assert property (p_comp_lock) else $error("composite accepted mode");

  property p_kdec;
    @(posedge clk) disable iff (!rstn)
      set_k && !bus_clear |=> cfg_q.eoi_en == !$past(num_q[0]) && cfg_q.hold_en == !$past(num_q[1]);
  endproperty
  a_kdec: assert property (p_kdec) else $error("EOI option decode wrong");

  property p_missing;
    @(posedge clk) disable iff (!rstn)
      missing && !bus_clear |=> missing_msg && $stable(chan2_q) && err_q;
  endproperty
  a_missing: assert property (p_missing) else $error("missing module not flagged");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      pst_q == P_IDLE && take && is_exec && cfg_q.hold_en && !bus_clear |=> nrfd_hold && !cmd_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("NRFD not held");

  property p_defer;
    @(posedge clk) disable iff (!rstn) pst_q == P_IDLE && !bus_clear |=> $stable(cfg_q);
  endproperty
  a_defer: assert property (p_defer) else $error("setting applied before execute");

  property p_mid_eoi;
    @(posedge clk) disable iff (!rstn) acc && !tx_last |=> talk_valid && !talk.eoi;
  endproperty
  a_mid_eoi: assert property (p_mid_eoi) else $error("EOI on inner byte");

  property p_last_term;
    @(posedge clk) disable iff (!rstn)
      tst_q == T_TERM1 && tload |=> talk.data == $past(cfg_q.term1) && talk.eoi == $past(cfg_q.eoi_en);
  endproperty
  a_last_term: assert property (p_last_term) else $error("EOI not on last terminator");

  property p_g7;
    @(posedge clk) disable iff (!rstn)
      acc && tx_last && unterminated_data_format |=> tst_q == T_DATA ##1 !talk_valid || tst_q == T_DATA;
  endproperty
  a_g7: assert property (p_g7) else $error("terminator sent for unterminated format");

  property p_err;
    @(posedge clk) disable iff (!rstn) bad |=> err_q;
  endproperty
  a_err: assert property (p_err) else $error("error not latched");

endmodule // chan_term_ctl

`default_nettype wire

// file: bench/bus_ctl_model.sv
// Bus controller model: writes command strings and drains talker bytes.
// Assumes the device clock; talker reads proceed one cycle in four when slow.
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model
  (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Listener side
    output logic [7:0]      cmd_data,
    output logic            cmd_valid,
    input  wire logic       cmd_ready,
    input  wire logic       nrfd_hold,
    // Talker side
    output logic            talk_ready
  );
  logic       slow;
  logic [1:0] cnt_q;

  initial
  begin
    cmd_data  = 8'h00;
    cmd_valid = 1'b0;
    slow      = 1'b0;
  end

  // ==========================================================
  // Command writer; terminator values stay below the letter codes
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      cmd_data  <= s[i];
      cmd_valid <= 1'b1;
      do @(posedge clk); while (cmd_ready !== 1'b1 || nrfd_hold === 1'b1);
    end
    cmd_valid <= 1'b0;
    cmd_data  <= ~cmd_data;
  endtask

  // ==========================================================
  // Talker pacing: free-running count gives talk_ready every cycle, or one in four when slow
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;

  assign talk_ready = !slow || (cnt_q == 2'h0);
endmodule // bus_ctl_model
`default_nettype wire

// file: bench/testbench.sv
// Bench: drives commands, panel writes and talker data; checks state and framing.
// Assumes bus_ctl_model as the bus controller and chan_term_ctl as the device.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import chan_term_pkg::*;
  typedef struct packed {
    logic        ch2;
    logic        comp;
    logic        err;
    logic        held;
    logic        care;
    logic [7:0]  panel;
    logic [15:0] disp;
    cfg_t        cfg;
  } snap_t;
  // ==========================================================
  // Signals
  logic        clk = 1'b0, rstn = 1'b0, bus_clear = 1'b0, err_clr = 1'b0, probe = 1'b0;
  logic        ch2_fit = 1'b1, srq_on = 1'b0, panel_wr = 1'b0, held = 1'b0;
  logic        tx_valid = 1'b0, tx_last = 1'b0, unt = 1'b0;
  logic [7:0]  tx_data = 8'h00, panel_val = 8'h00, p1, p2, p3, a, b, cmd_data, panel_active;
  logic [15:0] rd_ch1, rd_ch2, disp_reading;
  logic        cmd_valid, cmd_ready, nrfd_hold, error, srq_req, missing_msg, rdy_p;
  logic        chan2_sel, composite, tx_ready, talk_valid, talk_ready, ech2, ecomp, eerr, eh;
  cfg_t        cfg, ec;
  talk_t       talk;
  int          n_errors = 0, n_checks = 0, n_msg = 0, n_srq = 0, seed = 63;
  snap_t       sq[$];
  talk_t       tq[$];
  string       s;

  always #2.5 clk = ~clk;

  bus_ctl_model ctl (.clk(clk), .rstn(rstn), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .nrfd_hold(nrfd_hold), .talk_ready(talk_ready));
  chan_term_ctl dut (.clk(clk), .rstn(rstn), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .nrfd_hold(nrfd_hold), .bus_clear(bus_clear),
    .ch2_fitted_pin(ch2_fit), .srq_on_missing(srq_on), .err_clr(err_clr), .error(error),
    .srq_req(srq_req), .missing_msg(missing_msg), .rd_ch1(rd_ch1), .rd_ch2(rd_ch2),
    .panel_wr(panel_wr), .panel_val(panel_val), .panel_active(panel_active),
    .disp_reading(disp_reading), .chan2_sel(chan2_sel), .composite(composite), .cfg(cfg),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .unterminated_data_format(unt), .tx_ready(tx_ready), .talk(talk),
    .talk_valid(talk_valid), .talk_ready(talk_ready));

  // ==========================================================
  // Reporting and comparison
  task automatic bad(input string m);
    $display("unexpected at %0t: %s", $time, m);
    n_errors++;
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_talk(input talk_t t);
    n_checks++;
    if (tq.size() == 0)
      bad("talker byte not expected");
    else if (t !== tq.pop_front())
      bad("talker byte or eoi wrong");
  endtask

  task automatic chk_snap();
    snap_t x;
    snap_t e;
    n_checks++;
    x = '{chan2_sel, composite, error, held, 1'b0, panel_active, disp_reading, cfg};
    held = 1'b0;
    if (sq.size() == 0)
    begin
      bad("state not expected");
      return;
    end
    e = sq.pop_front();
    x.care = e.care;
    if (!e.care)
      {x.panel, x.disp} = '0;
    if (e.cfg.term_len < TLEN_TWO)
      x.cfg.term1 = 8'h00;
    if (e.cfg.term_len < TLEN_ONE)
      x.cfg.term0 = 8'h00;
    if (x !== e)
      bad("mode state wrong");
  endtask

  task automatic chk_cnt(input int got, input int want);
    n_checks++;
    if (got != want)
      bad("pulse count wrong");
  endtask

  // Output watcher: state at end of execution or on probe, talker bytes
  always @(posedge clk)
  begin
    if (missing_msg === 1'b1)
      n_msg++;
    if (srq_req === 1'b1)
      n_srq++;
    if (nrfd_hold === 1'b1)
      held = 1'b1;
    if (talk_valid === 1'b1 && talk_ready === 1'b1)
      chk_talk(talk);
    if ((cmd_ready === 1'b1 && rdy_p === 1'b0 && sq.size() > 0) || probe === 1'b1)
      chk_snap();
    rdy_p = cmd_ready;
  end

  // ==========================================================
  // Drivers
  task automatic push(input logic h, input logic c, input logic [7:0] pv);
    snap_t e;
    e = '{ech2, ecomp, eerr, h, c, pv, 16'h0000, ec};
    if (c)
      e.disp = ech2 ? rd_ch2 : rd_ch1;
    if (ec.term_len < TLEN_TWO)
      e.cfg.term1 = 8'h00;
    if (ec.term_len < TLEN_ONE)
      e.cfg.term0 = 8'h00;
    sq.push_back(e);
  endtask

  task automatic settle();
    for (int i = 0; i < 400 && (sq.size() > 0 || tq.size() > 0); i++)
      @(posedge clk);
    if (sq.size() > 0 || tq.size() > 0)
      bad("result missing");
    sq.delete();
    tq.delete();
  endtask

  task automatic cmd(input string c);
    push(eh, 1'b0, 8'h00);
    eh = ec.hold_en;
    ctl.send(c);
    settle();
  endtask

  task automatic peek(input logic [7:0] pv);
    push(1'b0, 1'b1, pv);
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    settle();
  endtask

  task automatic frame(input int n, input logic u);
    for (int i = 0; i < n; i++)
    begin
      a = 8'($random(seed));
      tx_data  <= a;
      tx_valid <= 1'b1;
      tx_last  <= (i == n - 1);
      unt      <= u;
      tq.push_back('{a, ec.eoi_en && i == n - 1 && (u || ec.term_len == TLEN_NONE)});
      do @(posedge clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    tx_last  <= 1'b0;
    if (!u && ec.term_len != TLEN_NONE)
      tq.push_back('{ec.term0, ec.eoi_en && ec.term_len == TLEN_ONE});
    if (!u && ec.term_len == TLEN_TWO)
      tq.push_back('{ec.term1, ec.eoi_en});
    settle();
  endtask

  task automatic wpanel(input logic [7:0] v);
    panel_wr  <= 1'b1;
    panel_val <= v;
    @(posedge clk);
    panel_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic clr();
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    eerr = 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    ec = CFG_RST;
    {ech2, ecomp, eerr, eh} = 4'h1;
    rd_ch1 <= 16'($random(seed));
    rd_ch2 <= 16'($random(seed));
    p1 = 8'($random(seed));
    p2 = ~p1;
    p3 = p1 ^ 8'h5a;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    wpanel(p1);
    peek(p1);
    frame(3, 1'b0);
    $display("test defaults done");
    for (int k = 4; k >= 0; k--)
    begin
      eerr = (k == 4);
      if (k < 4)
        {ec.hold_en, ec.eoi_en} = ~2'(k);
      cmd($sformatf("K%0dX", k));
      frame(2, 1'b0);
      clr();
    end
    $display("test eoi_holdoff done");
    ctl.slow = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      a = 8'($random(seed) & 63);
      b = 8'($random(seed) & 63);
      ec.term_len = 2'(2 - i);
      ec.term0 = a;
      ec.term1 = b;
      s = (i == 0) ? $sformatf("Y%0d,%0dX", a, b) : (i == 1) ? $sformatf("Y%0dX", a) : "YX";
      cmd(s);
      frame(3, 1'b0);
    end
    ec = CFG_RST;
    cmd("Y13,10X");
    frame(2, 1'b1);
    ctl.slow = 1'b0;
    $display("test terminator done");
    ech2 = 1'b1;
    cmd("C2X");
    frame(1, 1'b0);
    wpanel(p2);
    peek(p2);
    ech2 = 1'b0;
    cmd("C1X");
    peek(p1);
    $display("test channel done");
    ecomp = 1'b1;
    cmd("C12X");
    wpanel(p3);
    eerr = 1'b1;
    cmd("K3X");
    ecomp = 1'b0;
    cmd("C1X");
    peek(p1);
    clr();
    $display("test composite done");
    ch2_fit <= 1'b0;
    srq_on  <= 1'b1;
    repeat (6) @(posedge clk);
    eerr = 1'b1;
    cmd("C2X");
    chk_cnt(n_msg, 1);
    chk_cnt(n_srq, 1);
    ch2_fit <= 1'b1;
    srq_on  <= 1'b0;
    clr();
    $display("test missing done");
    ec.hold_en = 1'b0;
    cmd("K1K2X");
    ctl.send("C2K3");
    bus_clear <= 1'b1;
    @(posedge clk);
    bus_clear <= 1'b0;
    repeat (2) @(posedge clk);
    ec = CFG_RST;
    eh = 1'b1;
    peek(p1);
    cmd("X");
    frame(2, 1'b0);
    $display("test order_clear done");
    results();
  end

  initial
  begin
    #(20000 * 5);
    bad("watchdog expired");
    results();
  end
endmodule // testbench
`default_nettype wire
